/* design/twc_pkg.sv */
// Constants and carrier types for the timer mode and control register block.
// Assumes a single 10 MHz ref_clk domain and Avalon-MM word access from software.
package twc_pkg;

  localparam int ADDR_W = 6;

  localparam logic [5:0] OFS_MODE    = 6'h00;
  localparam logic [5:0] OFS_CONTROL = 6'h04;
  localparam logic [5:0] OFS_COUNTER = 6'h08;
  localparam logic [5:0] OFS_GRA     = 6'h0c;
  localparam logic [5:0] OFS_GRB     = 6'h10;
  localparam logic [5:0] OFS_GRC     = 6'h14;
  localparam logic [5:0] OFS_GRD     = 6'h18;
  localparam logic [5:0] OFS_STATUS  = 6'h1c;

  localparam int BIT_OVERFLOW = 7;

  localparam logic [2:0] CKS_DIV1 = 3'h0;
  localparam logic [2:0] CKS_DIV2 = 3'h1;
  localparam logic [2:0] CKS_DIV4 = 3'h2;
  localparam logic [2:0] CKS_DIV8 = 3'h3;

  localparam logic [15:0] COUNT_MAX   = 16'hffff;
  localparam logic [15:0] RESET_WORD  = 16'h0000;
  localparam logic [15:0] RESET_GR    = 16'hffff;

  typedef struct packed {
    logic counterStart;
    logic reserved6;
    logic bufferEnableB;
    logic bufferEnableA;
    logic reserved3;
    logic pwmSelectD;
    logic pwmSelectC;
    logic pwmSelectB;
  } twc_mode_t;

  typedef struct packed {
    logic       clearOnMatchA;
    logic [2:0] clockSelect;
    logic [3:0] outputLevel;
  } twc_control_t;

  localparam twc_mode_t    MODE_RESET    = twc_mode_t'(8'h00);
  localparam twc_control_t CONTROL_RESET = twc_control_t'(8'h00);
  localparam logic [7:0]   MODE_RSV_ONES = 8'h48;

endpackage

/* design/twc_edge_det.sv */
// Rising-edge detector for the external event input.
// Assumes the pin is already synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module twc_edge_det (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      rise
);
  logic pinPrev;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinPrev <= 1'b0;
    end else begin
      pinPrev <= pin;
    end
  end

  assign rise = pin & ~pinPrev;
endmodule
`default_nettype wire

/* design/twc_tick_sel.sv */
// Count clock selector: produces one-cycle count ticks from the chosen source.
// Assumes subclock and event inputs arrive as single-cycle pulses on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module twc_tick_sel
  import twc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] clockSelect,
  input  wire logic       lowPowerMode,
  input  wire logic       subClockTick,
  input  wire logic       eventRise,
  output logic            tick
);
  logic [2:0] prescale;

  // The prescaler runs free so a divider change takes effect at once.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale <= 3'h0;
    end else begin
      prescale <= prescale + 3'h1;
    end
  end

  always_comb begin
    if (clockSelect[2]) begin
      tick = eventRise;
    end else begin
      case (clockSelect)
        CKS_DIV1: tick = lowPowerMode ? subClockTick : 1'b1;
        CKS_DIV2: tick = prescale[0];
        CKS_DIV4: tick = &prescale[1:0];
        CKS_DIV8: tick = &prescale;
        default:  tick = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* design/twc_timer.sv */
// Timer mode and control registers with the 16-bit counter they steer.
// Assumes an Avalon-MM master on ref_clk; the answer comes one cycle after the request.
//
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module twc_timer
  import twc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  input  wire logic              externalEventPin,
  input  wire logic              lowPowerMode,
  input  wire logic              subClockTick,
  output logic [3:0]             channelOut,
  output logic [3:0]             channelOutEnable_n,
  output logic [3:0]             pwmActive
);
  twc_mode_t    modeReg;
  twc_control_t controlReg;
  logic [15:0]  counter;
  logic [15:0]  general_register_a;
  logic [15:0]  general_register_b;
  logic [15:0]  general_register_c;
  logic [15:0]  general_register_d;
  logic         overflowFlag;
  logic [3:0]   matchFlag;
  logic         ack;
  logic         eventRise;
  logic         tick;
  logic         running;
  logic [3:0]   match;
  logic         wrMode;
  logic         wrControl;
  logic         wrCounter;
  logic         wrGrA;
  logic         wrGrB;
  logic         wrGrC;
  logic         wrGrD;
  logic         wrStatus;
  logic [15:0]  wrWord;
  logic [31:0]  next_readdata;
  logic         clearNow;

  twc_edge_det u_edge (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .pin     (externalEventPin),
    .rise    (eventRise)
  );

  twc_tick_sel u_tick (
    .ref_clk      (ref_clk),
    .reset_n      (reset_n),
    .clockSelect  (controlReg.clockSelect),
    .lowPowerMode (lowPowerMode),
    .subClockTick (subClockTick),
    .eventRise    (eventRise),
    .tick         (tick)
  );

  // Every access waits exactly one cycle; write and read both take effect on that first edge.
  assign waitrequest = (read | write) & ~ack;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (read | write) & ~ack;
    end
  end

  assign wrMode    = write & ~ack & byteenable[0] & (address == OFS_MODE);
  assign wrControl = write & ~ack & byteenable[0] & (address == OFS_CONTROL);
  assign wrCounter = write & ~ack & (address == OFS_COUNTER);
  assign wrGrA     = write & ~ack & (address == OFS_GRA);
  assign wrGrB     = write & ~ack & (address == OFS_GRB);
  assign wrGrC     = write & ~ack & (address == OFS_GRC);
  assign wrGrD     = write & ~ack & (address == OFS_GRD);
  assign wrStatus  = write & ~ack & byteenable[0] & (address == OFS_STATUS);

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  assign wrWord = merge16(counter, writedata, byteenable);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      modeReg <= MODE_RESET;
    end else if (wrMode) begin
      modeReg <= twc_mode_t'(writedata[7:0] & ~MODE_RSV_ONES);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      controlReg <= CONTROL_RESET;
    end else if (wrControl) begin
      controlReg <= twc_control_t'(writedata[7:0]);
    end
  end

  assign running = modeReg.counterStart;
  assign match[0] = running & tick & (counter == general_register_a);
  assign match[1] = running & tick & (counter == general_register_b);
  assign match[2] = running & tick & (counter == general_register_c);
  assign match[3] = running & tick & (counter == general_register_d);
  assign clearNow = controlReg.clearOnMatchA & match[0];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      counter <= RESET_WORD;
    end else if (wrCounter) begin
      counter <= wrWord;
    end else if (clearNow) begin
      counter <= RESET_WORD;
    end else if (running & tick) begin
      counter <= counter + 16'h0001;
    end
  end

  // In buffer mode a match moves the buffer into its partner; software writes win.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      general_register_a <= RESET_GR;
      general_register_b <= RESET_GR;
      general_register_c <= RESET_GR;
      general_register_d <= RESET_GR;
    end else begin
      if (wrGrA) begin
        general_register_a <= merge16(general_register_a, writedata, byteenable);
      end else if (modeReg.bufferEnableA & match[0]) begin
        general_register_a <= general_register_c;
      end
      if (wrGrB) begin
        general_register_b <= merge16(general_register_b, writedata, byteenable);
      end else if (modeReg.bufferEnableB & match[1]) begin
        general_register_b <= general_register_d;
      end
      if (wrGrC) begin
        general_register_c <= merge16(general_register_c, writedata, byteenable);
      end
      if (wrGrD) begin
        general_register_d <= merge16(general_register_d, writedata, byteenable);
      end
    end
  end

  // A flag set by hardware in the same cycle as a software clear stays set.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      overflowFlag <= 1'b0;
      matchFlag    <= 4'h0;
    end else begin
      if (running & tick & ~clearNow & ~wrCounter & (counter == COUNT_MAX)) begin
        overflowFlag <= 1'b1;
      end else if (wrStatus & ~writedata[BIT_OVERFLOW]) begin
        overflowFlag <= 1'b0;
      end
      matchFlag <= match | (matchFlag & ~({4{wrStatus}} & ~writedata[3:0]));
    end
  end

  // A buffer register still compares and sets its match flag; it drives its PWM output only when it is not a buffer.
  assign pwmActive = {modeReg.pwmSelectD, modeReg.pwmSelectC, modeReg.pwmSelectB, 1'b0};
  assign channelOutEnable_n = 4'h0;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      channelOut <= 4'h0;
    end else if (wrControl) begin
      channelOut <= writedata[3:0];
    end else begin
      if (modeReg.pwmSelectB) begin
        if (match[1]) begin
          channelOut[1] <= 1'b0;
        end else if (match[0]) begin
          channelOut[1] <= 1'b1;
        end
      end
      if (modeReg.pwmSelectC & ~modeReg.bufferEnableA) begin
        if (match[2]) begin
          channelOut[2] <= 1'b0;
        end else if (match[0]) begin
          channelOut[2] <= 1'b1;
        end
      end
      if (modeReg.pwmSelectD & ~modeReg.bufferEnableB) begin
        if (match[3]) begin
          channelOut[3] <= 1'b0;
        end else if (match[0]) begin
          channelOut[3] <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    case (address)
      OFS_MODE:    next_readdata[7:0] = modeReg | MODE_RSV_ONES;
      OFS_CONTROL: next_readdata[7:0] = controlReg;
      OFS_COUNTER: next_readdata[15:0] = counter;
      OFS_GRA:     next_readdata[15:0] = general_register_a;
      OFS_GRB:     next_readdata[15:0] = general_register_b;
      OFS_GRC:     next_readdata[15:0] = general_register_c;
      OFS_GRD:     next_readdata[15:0] = general_register_d;
      OFS_STATUS:  next_readdata[7:0] = {overflowFlag, 3'h7, matchFlag};
      default:     next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~ack) begin
      readdata <= next_readdata;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_idle_no_write;
    !running && !wrCounter;
  endsequence

  sequence s_step;
    running && tick && !clearNow && !wrCounter;
  endsequence

  sequence s_ctrl_write;
    wrControl ##1 ack;
  endsequence

  sequence s_div8_tick;
    controlReg.clockSelect == CKS_DIV8 && tick;
  endsequence

  sequence s_level_quiet;
    !wrControl && !(|pwmActive);
  endsequence

  stop_hold_a: assert property (s_idle_no_write |=> counter == $past(counter))
    else $error("Counter moved while stopped.");

  count_step_a: assert property (s_step |=> counter == $past(counter) + 16'h0001)
    else $error("Counter did not step by one.");

  clear_match_a: assert property (clearNow && !wrCounter |=> counter == RESET_WORD)
    else $error("Counter not cleared on match A.");

  buffer_a_a: assert property (
    modeReg.bufferEnableA && match[0] && !wrGrA |=> general_register_a == $past(general_register_c))
    else $error("Buffer C not moved into A.");

  buffer_b_a: assert property (
    modeReg.bufferEnableB && match[1] && !wrGrB |=> general_register_b == $past(general_register_d))
    else $error("Buffer D not moved into B.");

  indep_a_a: assert property (!modeReg.bufferEnableA && !wrGrA |=> general_register_a == $past(general_register_a))
    else $error("Register A changed without buffer mode.");

  overflow_set_a: assert property (
    (s_step and (counter == COUNT_MAX)) |=> overflowFlag && counter == RESET_WORD)
    else $error("Overflow flag missed on wrap.");

  level_now_a: assert property (
    s_ctrl_write |-> channelOut == $past(writedata[3:0]))
    else $error("Output level not applied at once.");

  reserved_read_a: assert property (
    read && !ack && address == OFS_MODE |=> readdata[6] && readdata[3])
    else $error("Reserved mode bits not read as one.");

  ext_event_a: assert property (controlReg.clockSelect[2] |-> tick == eventRise)
    else $error("External clock select not honoured.");

  sub_clock_a: assert property (
    controlReg.clockSelect == CKS_DIV1 && lowPowerMode |-> tick == subClockTick)
    else $error("Subclock not used in low power.");

  div8_tick_a: assert property (
    s_div8_tick |=> (!tick || controlReg.clockSelect != CKS_DIV8) [*7])
    else $error("Divide by eight ticks too often.");

  pwm_b_a: assert property (
    modeReg.pwmSelectB && match[1] && !wrControl |=> !channelOut[1])
    else $error("PWM B did not fall on its match.");

  pwm_b_set_a: assert property (
    modeReg.pwmSelectB && match[0] && !match[1] && !wrControl |=> channelOut[1])
    else $error("PWM B did not rise on match A.");

  pwm_c_a: assert property (
    modeReg.pwmSelectC && !modeReg.bufferEnableA && match[2] && !wrControl |=> !channelOut[2])
    else $error("PWM C did not fall on its match.");

  pwm_c_set_a: assert property (
    modeReg.pwmSelectC && !modeReg.bufferEnableA && match[0] && !match[2] && !wrControl
    |=> channelOut[2])
    else $error("PWM C did not rise on match A.");

  pwm_d_a: assert property (
    modeReg.pwmSelectD && !modeReg.bufferEnableB && match[3] && !wrControl |=> !channelOut[3])
    else $error("PWM D did not fall on its match.");

  pwm_d_set_a: assert property (
    modeReg.pwmSelectD && !modeReg.bufferEnableB && match[0] && !match[3] && !wrControl
    |=> channelOut[3])
    else $error("PWM D did not rise on match A.");

  level_hold_a: assert property (s_level_quiet |=> channelOut == $past(channelOut))
    else $error("Output level moved without a write.");

  div1_tick_a: assert property (
    controlReg.clockSelect == CKS_DIV1 && !lowPowerMode |-> tick)
    else $error("Undivided clock missed a tick.");

  div2_tick_a: assert property (
    controlReg.clockSelect == CKS_DIV2 && !tick |=> tick || controlReg.clockSelect != CKS_DIV2)
    else $error("Divide by two missed a tick.");

  div4_tick_a: assert property (
    controlReg.clockSelect == CKS_DIV4 && tick |=> (!tick || controlReg.clockSelect != CKS_DIV4) [*3])
    else $error("Divide by four ticks too often.");

  div8_period_a: assert property (
    s_div8_tick |-> ##8 (tick || controlReg.clockSelect != CKS_DIV8))
    else $error("Divide by eight missed a tick.");

  start_write_a: assert property (wrMode |=> running == $past(writedata[7]))
    else $error("Counter start bit not taken.");

  clock_write_a: assert property (
    wrControl |=> controlReg.clockSelect == $past(writedata[6:4]))
    else $error("Clock select not taken.");

  hold_no_tick_a: assert property (
    running && !tick && !wrCounter |=> counter == $past(counter))
    else $error("Counter moved without a tick.");

  ovf_hold_a: assert property (overflowFlag && !wrStatus |=> overflowFlag)
    else $error("Overflow flag lost without a clear.");

  indep_b_a: assert property (!modeReg.bufferEnableB && !wrGrB |=> general_register_b == $past(general_register_b))
    else $error("Register B changed without buffer mode.");

endmodule
`default_nettype wire

/* test/twc_pin_model.sv */
// Far-side model of the timer pins: external event input and subclock pulse.
// Assumes everything is synchronous to ref_clk, as the timer's input ports expect.
`timescale 1ns/100ps
`default_nettype none
module twc_pin_model (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  output logic      externalEventPin,
  output logic      subClockTick
);
  logic [1:0] phase;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // A fixed period of four cycles keeps every count window exact.
  assign externalEventPin = phase[1];
  assign subClockTick     = (phase == 2'h3);
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the timer mode and control registers.
// Assumes one 10 MHz clock and an Avalon-MM slave answering within a few cycles.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import twc_pkg::*;
;
  logic              ref_clk;
  logic              reset_n;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [31:0]       writedata;
  logic [3:0]        byteenable;
  logic [31:0]       readdata;
  logic              waitrequest;
  logic              externalEventPin;
  logic              lowPowerMode;
  logic              subClockTick;
  logic [3:0]        channelOut;
  logic [3:0]        channelOutEnable_n;
  logic [3:0]        pwmActive;
  logic [31:0]       q;
  logic [31:0]       r;
  int                miscompares = 0;
  int                comparisons = 0;
  logic [7:0]        bufModes [2] = '{8'h90, 8'ha0};
  logic [15:0]       expA [2] = '{16'h0014, 16'h0005};
  logic [15:0]       expB [2] = '{16'h0006, 16'h001e};

  twc_timer i_dut (
    .ref_clk            (ref_clk),
    .reset_n            (reset_n),
    .address            (address),
    .read               (read),
    .write              (write),
    .writedata          (writedata),
    .byteenable         (byteenable),
    .readdata           (readdata),
    .waitrequest        (waitrequest),
    .externalEventPin   (externalEventPin),
    .lowPowerMode       (lowPowerMode),
    .subClockTick       (subClockTick),
    .channelOut         (channelOut),
    .channelOutEnable_n (channelOutEnable_n),
    .pwmActive          (pwmActive)
  );

  twc_pin_model i_pins (
    .ref_clk          (ref_clk),
    .reset_n          (reset_n),
    .externalEventPin (externalEventPin),
    .subClockTick     (subClockTick)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle; the request is held until waitrequest is seen low at an edge.
  task automatic busCycle(input logic isRead, input logic [5:0] a, input logic [31:0] d,
                          output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    address   <= a;
    writedata <= d;
    read      <= isRead;
    write     <= !isRead;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin
      miscompares++;
      $display("Error at %0t: bus answer timed out", $time);
      complete_run();
    end
  endtask

  task automatic avWrite(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] unused;
    busCycle(1'b0, a, d, unused);
  endtask

  task automatic avRead(input logic [5:0] a, output logic [31:0] d);
    busCycle(1'b1, a, 32'h0, d);
  endtask

  task automatic checkReg(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] d;
    avRead(a, d);
    checkVal(d, exp);
  endtask

  // Counter delta over 32 cycles between two read captures.
  task automatic measureRate(input logic [7:0] ctrl, input logic [15:0] expDelta);
    logic [31:0] c1;
    logic [31:0] c2;
    avWrite(OFS_MODE, 32'h0);
    avWrite(OFS_CONTROL, {24'h0, ctrl});
    avWrite(OFS_COUNTER, 32'h0);
    avWrite(OFS_MODE, 32'h80);
    avRead(OFS_COUNTER, c1);
    repeat (29) @(posedge ref_clk);
    avRead(OFS_COUNTER, c2);
    checkVal({16'h0, c2[15:0] - c1[15:0]}, {16'h0, expDelta});
  endtask

  initial begin
    reset_n      = 1'b0;
    address      = '0;
    read         = 1'b0;
    write        = 1'b0;
    writedata    = 32'h0;
    byteenable   = 4'hf;
    lowPowerMode = 1'b0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    checkReg(OFS_MODE, 32'h48);
    checkReg(OFS_CONTROL, 32'h0);
    checkReg(OFS_COUNTER, 32'h0);
    checkReg(6'h20, 32'h0);
    avWrite(OFS_MODE, 32'hff);
    checkReg(OFS_MODE, 32'hff);
    avWrite(OFS_MODE, 32'h0);
    checkReg(OFS_MODE, 32'h48);
    for (int i = 0; i < 5; i++) begin
      avWrite(OFS_CONTROL, {28'h0, 4'h1 << i});
      checkVal({28'h0, channelOut}, {28'h0, 4'h1 << i});
    end
    checkVal({28'h0, channelOutEnable_n}, 32'h0);
    for (int i = 0; i < 3; i++) begin
      avWrite(OFS_MODE, {29'h0, 3'h1 << i});
      checkVal({28'h0, pwmActive}, {28'h0, 4'h2 << i});
    end
    avWrite(OFS_MODE, 32'h0);
    avWrite(OFS_COUNTER, 32'h1234);
    repeat (10) @(posedge ref_clk);
    checkReg(OFS_COUNTER, 32'h1234);
    for (int k = 0; k < 4; k++) begin
      measureRate({1'b0, 3'(k), 4'h0}, 16'(32 >> k));
    end
    for (int k = 4; k < 8; k++) begin
      measureRate({1'b0, 3'(k), 4'h0}, 16'h8);
    end
    lowPowerMode <= 1'b1;
    measureRate(8'h00, 16'h8);
    lowPowerMode <= 1'b0;
    avWrite(OFS_GRA, 32'h9);
    avWrite(OFS_CONTROL, 32'h80);
    avWrite(OFS_COUNTER, 32'h0);
    avWrite(OFS_MODE, 32'h80);
    for (int i = 0; i < 6; i++) begin
      avRead(OFS_COUNTER, q);
      checkVal({31'h0, q[15:0] < 16'ha}, 32'h1);
      repeat (3) @(posedge ref_clk);
    end
    avWrite(OFS_MODE, 32'h0);
    avWrite(OFS_CONTROL, 32'h0);
    avWrite(OFS_STATUS, 32'h0);
    avRead(OFS_STATUS, q);
    checkVal({31'h0, q[7]}, 32'h0);
    avWrite(OFS_COUNTER, 32'hfff0);
    avWrite(OFS_MODE, 32'h80);
    repeat (30) @(posedge ref_clk);
    avRead(OFS_STATUS, q);
    checkVal({31'h0, q[7]}, 32'h1);
    // Buffer case A then B; the counter is stopped before reading back.
    for (int i = 0; i < 2; i++) begin
      avWrite(OFS_MODE, 32'h0);
      avWrite(OFS_GRA, 32'h5);
      avWrite(OFS_GRB, 32'h6);
      avWrite(OFS_GRC, 32'h14);
      avWrite(OFS_GRD, 32'h1e);
      avWrite(OFS_COUNTER, 32'h0);
      avWrite(OFS_MODE, {24'h0, bufModes[i]});
      repeat (20) @(posedge ref_clk);
      avWrite(OFS_MODE, 32'h0);
      avRead(OFS_GRA, q);
      avRead(OFS_GRB, r);
      checkVal({16'h0, q[15:0]}, {16'h0, expA[i]});
      checkVal({16'h0, r[15:0]}, {16'h0, expB[i]});
    end
    // PWM on B drops the level at match B; a normal channel keeps its written level.
    for (int i = 0; i < 2; i++) begin
      avWrite(OFS_MODE, 32'h0);
      avWrite(OFS_GRA, 32'hffff);
      avWrite(OFS_GRB, 32'h4);
      avWrite(OFS_CONTROL, 32'h2);
      avWrite(OFS_COUNTER, 32'h0);
      avWrite(OFS_MODE, 32'h80 | 32'(1 - i));
      repeat (10) @(posedge ref_clk);
      avWrite(OFS_MODE, 32'h0);
      checkVal({31'h0, channelOut[1]}, 32'(i));
    end
    complete_run();
  end
endmodule
`default_nettype wire
